// ===== common/tcsr_regs.vh
// Register offsets, field positions and reset values of the timer channel register block.
// Included by the design; assumes byte addressing on a 32-bit Avalon-MM slave.
`ifndef TCSR_REGS_VH
`define TCSR_REGS_VH
`define TCSR_OFF_CAPA 8'h14
`define TCSR_OFF_CAPB 8'h18
`define TCSR_OFF_PERC 8'h1c
`define TCSR_OFF_STAT 8'h20
`define TCSR_OFF_IEN 8'h24
`define TCSR_OFF_IDIS 8'h28
`define TCSR_OFF_IMASK 8'h2c
`define TCSR_BIT_OVF 0
`define TCSR_BIT_LOVR 1
`define TCSR_BIT_MATA 2
`define TCSR_BIT_MATB 3
`define TCSR_BIT_MATC 4
`define TCSR_BIT_LDA 5
`define TCSR_BIT_LDB 6
`define TCSR_BIT_ETRG 7
`define TCSR_BIT_CLKON 16
`define TCSR_BIT_LINEA 17
`define TCSR_BIT_LINEB 18
`define TCSR_RST_VAL16 16'h0000
`define TCSR_RST_FLAGS 8'h00
`define TCSR_WAVE_MODE 1'b1
`endif

// ===== logic/tcsr_chan_regs.v
// Timer channel register block: values A/B/C, status flags, interrupt enables and mask.
// Assumes counter-side event strobes and levels are on core_clk; I/O pins are asynchronous.
`timescale 1ns/1ps
`include "tcsr_regs.vh"

module tcsr_chan_regs (
  input wire core_clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire waveMode,
  input wire overflowEvt,
  input wire matchAEvt,
  input wire matchBEvt,
  input wire matchCEvt,
  input wire loadAEvt,
  input wire loadBEvt,
  input wire [15:0] captureAIn,
  input wire [15:0] captureBIn,
  input wire extTriggerEvt,
  input wire counterClockOn,
  input wire chanIoAPin,
  input wire chanIoBPin,
  input wire chanIoADrive,
  input wire chanIoBDrive,
  output reg [15:0] compareBValue,
  output reg [15:0] periodCompareValue,
  output reg irqOut
);

  // Register map, byte offsets on the slave:
  //   0x14 value A, loaded by the counter in capture, written in waveform
  //   0x18 value B, same access as value A
  //   0x1c value C, read-write in every mode
  //   0x20 status, sticky flags in 7:0, live levels in 18:16
  //   0x24 enable command, write-only, reads zero
  //   0x28 disable command, write-only, reads zero
  //   0x2c interrupt mask view, read-only
  // Status bits: 0 overflow, 1 load overrun, 2 match A, 3 match B,
  //   4 match C, 5 load A, 6 load B, 7 external trigger.
  // Values sit in bits 15:0; bits 31:16 of a value read as zero.

  // Things a user must know:
  //   reading status clears every sticky flag at the taking edge;
  //   an event in that same cycle still sets its flag, so none is lost;
  //   flags of the other mode are held at zero, so a mode switch clears them;
  //   the command registers act on byte lane 0 only;
  //   in capture mode, live pin levels reach status two clocks late through the synchroniser.

  // Stored values
  reg [15:0] captureAQ;
  reg [15:0] captureBQ;
  reg [15:0] periodQ;

  // Sticky flags and interrupt mask, one flop per bit in the loops below
  wire [7:0] flagsQ;
  wire [7:0] maskQ;

  // Load-pending markers for the overrun check
  reg pendAQ;
  reg pendBQ;

  // Bus answer state and the read multiplexer result
  reg ackQ;
  reg [31:0] rdData;

  // Per-flag events, mode gating and next flags
  wire [7:0] flagEvt;
  wire [7:0] flagAllow;
  wire [7:0] flagsD;

  // Raw and synchronised channel pins
  wire [1:0] pinRaw;
  wire [1:0] pinSync;

  // Reset patterns, indexable per bit
  localparam [7:0] FLAG_RST = `TCSR_RST_FLAGS;
  localparam [7:0] MASK_RST = `TCSR_RST_FLAGS;

  // Merges a write into a 16-bit value honouring the low byte lanes
  function [15:0] mergeLow;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      mergeLow = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // True when the bus address selects the given register offset
  function addrHit;
    input [7:0] adr;
    input [7:0] off;
    begin
      addrHit = (adr == off);
    end
  endfunction

  // True when the low byte lane, which the commands use, is written
  function laneLow;
    input [3:0] be;
    begin
      laneLow = be[0];
    end
  endfunction

  // Flags that may be set in the given mode
  function [7:0] allowFor;
    input cap;
    begin
      allowFor = 8'hff;
      allowFor[`TCSR_BIT_LOVR] = cap;
      allowFor[`TCSR_BIT_MATA] = ~cap;
      allowFor[`TCSR_BIT_MATB] = ~cap;
      allowFor[`TCSR_BIT_LDA] = cap;
      allowFor[`TCSR_BIT_LDB] = cap;
    end
  endfunction

  // Assembles the status word from flags and live levels
  function [31:0] statusWord;
    input [7:0] flags;
    input clkOn;
    input la;
    input lb;
    begin
      statusWord = 32'h00000000;
      statusWord[7:0] = flags;
      statusWord[`TCSR_BIT_CLKON] = clkOn;
      statusWord[`TCSR_BIT_LINEA] = la;
      statusWord[`TCSR_BIT_LINEB] = lb;
    end
  endfunction

  // A request is taken once; the cycle after it is the answer cycle
  wire req = (avs_read | avs_write) & ~ackQ;
  wire wrOk = avs_write & ~ackQ;
  wire rdOk = avs_read & ~ackQ;

  // Decoded register strobes of the taken request
  wire stRead = rdOk & addrHit(avs_address, `TCSR_OFF_STAT);
  wire rdA = rdOk & addrHit(avs_address, `TCSR_OFF_CAPA);
  wire rdB = rdOk & addrHit(avs_address, `TCSR_OFF_CAPB);
  wire wrA = wrOk & addrHit(avs_address, `TCSR_OFF_CAPA);
  wire wrB = wrOk & addrHit(avs_address, `TCSR_OFF_CAPB);
  wire wrC = wrOk & addrHit(avs_address, `TCSR_OFF_PERC);
  wire wrEn = wrOk & addrHit(avs_address, `TCSR_OFF_IEN) & laneLow(avs_byteenable);
  wire wrDis = wrOk & addrHit(avs_address, `TCSR_OFF_IDIS) & laneLow(avs_byteenable);

  // Mode decode and mirrored line levels
  wire capMode = (waveMode != `TCSR_WAVE_MODE);
  wire lineA = capMode ? pinSync[0] : chanIoADrive;
  wire lineB = capMode ? pinSync[1] : chanIoBDrive;

  // A second load of a still unread value is an overrun
  wire overrunEvt = (loadAEvt & pendAQ) | (loadBEvt & pendBQ);

  // Raw pins gathered so the synchroniser can be a loop
  assign pinRaw = {chanIoBPin, chanIoAPin};

  // Events in status bit order
  assign flagEvt = {extTriggerEvt, loadBEvt, loadAEvt, matchCEvt,
    matchBEvt, matchAEvt, overrunEvt, overflowEvt};

  // Mode gating of the flags
  assign flagAllow = allowFor(capMode);

  // Unmasked flags that raise the interrupt on the next edge
  wire [7:0] irqHit = flagsD & maskQ;

  // Two-flop synchroniser per channel pin; only the second stage is read
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : pinSyncGen
      reg s1Q;
      reg s2Q;
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          s1Q <= 1'b0;
          s2Q <= 1'b0;
        end else begin
          s1Q <= pinRaw[gi];
          s2Q <= s1Q;
        end
      end
      assign pinSync[gi] = s2Q;
    end
  endgenerate

  // One sticky flag per status bit
  genvar fi;
  generate
    for (fi = 0; fi < 8; fi = fi + 1) begin : flagGen
      reg flagQ;
      // Set wins over the read-clear; a disallowed flag is held at zero
      assign flagsD[fi] = flagAllow[fi] & (flagEvt[fi] | (flagQ & ~stRead));
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          flagQ <= FLAG_RST[fi];
        end else begin
          flagQ <= flagsD[fi];
        end
      end
      assign flagsQ[fi] = flagQ;
    end
  endgenerate

  // One mask bit per status flag: enable sets, disable clears
  genvar mi;
  generate
    for (mi = 0; mi < 8; mi = mi + 1) begin : maskGen
      reg bitQ;
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          bitQ <= MASK_RST[mi];
        end else if (wrEn & avs_writedata[mi]) begin
          bitQ <= 1'b1;
        end else if (wrDis & avs_writedata[mi]) begin
          bitQ <= 1'b0;
        end
      end
      assign maskQ[mi] = bitQ;
    end
  endgenerate

  // Value A: counter load in capture, software write in waveform
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      captureAQ <= `TCSR_RST_VAL16;
    end else if (capMode & loadAEvt) begin
      captureAQ <= captureAIn;
    end else if (~capMode & wrA) begin
      captureAQ <= mergeLow(captureAQ, avs_writedata, avs_byteenable);
    end
  end

  // Value B: counter load in capture, software write in waveform
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      captureBQ <= `TCSR_RST_VAL16;
    end else if (capMode & loadBEvt) begin
      captureBQ <= captureBIn;
    end else if (~capMode & wrB) begin
      captureBQ <= mergeLow(captureBQ, avs_writedata, avs_byteenable);
    end
  end

  // Value C: software write in every mode
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periodQ <= `TCSR_RST_VAL16;
    end else if (wrC) begin
      periodQ <= mergeLow(periodQ, avs_writedata, avs_byteenable);
    end
  end

  // A load of A arms the overrun check until A is read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pendAQ <= 1'b0;
    end else begin
      pendAQ <= capMode & (loadAEvt | (pendAQ & ~rdA));
    end
  end

  // A load of B arms the overrun check until B is read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pendBQ <= 1'b0;
    end else begin
      pendBQ <= capMode & (loadBEvt | (pendBQ & ~rdB));
    end
  end

  // Bus timing: a request is taken at the first edge that sees it,
  // waitrequest falls for exactly one cycle after it, and the master
  // drops the request at the edge that samples waitrequest low.

  // Marks the answer cycle so that a held request is taken only once
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= req;
    end
  end

  // Waitrequest is high when idle and low in the answer cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~req;
    end
  end

  // Read data captured at the taking edge, held until the next read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rdOk) begin
      avs_readdata <= rdData;
    end
  end

  // Read multiplexer; unmapped and write-only offsets read zero
  always @* begin
    rdData = 32'h00000000;
    case (avs_address)
      `TCSR_OFF_CAPA: rdData[15:0] = captureAQ;
      `TCSR_OFF_CAPB: rdData[15:0] = captureBQ;
      `TCSR_OFF_PERC: rdData[15:0] = periodQ;
      `TCSR_OFF_STAT: rdData = statusWord(flagsQ, counterClockOn, lineA, lineB);
      `TCSR_OFF_IMASK: rdData[7:0] = maskQ;
      default: rdData = 32'h00000000;
    endcase
  end

  // Registered copy of value B for the compare logic
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compareBValue <= `TCSR_RST_VAL16;
    end else begin
      compareBValue <= captureBQ;
    end
  end

  // Registered copy of value C for the compare logic
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periodCompareValue <= `TCSR_RST_VAL16;
    end else begin
      periodCompareValue <= periodQ;
    end
  end

  // Level interrupt, high while an unmasked flag is set
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |irqHit;
    end
  end

endmodule // tcsr_chan_regs

// ===== bench/tcsr_chk.sv
// Checker for the timer channel register block, bound to its top.
// Assumes one clock domain and the hand-over bus timing.
`timescale 1ns/1ps
module tcsr_chk (
  input wire core_clk,
  input wire rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire waveMode,
  input wire counterClockOn,
  input wire [15:0] compareBValue,
  input wire [15:0] periodCompareValue,
  input wire irqOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Request taken at this edge, and its kinds
  wire tk = (avs_read | avs_write) & avs_waitrequest;
  wire wrT = tk & avs_write;
  wire rdS = tk & avs_read & avs_address == 8'h20;
  a_ack_next: assert property (tk |=> !avs_waitrequest) else $error("late ack");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  a_perc_copy: assert property (wrT && avs_address == 8'h1c
    |-> ##2 periodCompareValue == $past(avs_writedata[15:0], 2)) else $error("bad C");
  a_capb_wave: assert property (wrT && avs_address == 8'h18 && waveMode
    |-> ##2 compareBValue == $past(avs_writedata[15:0], 2)) else $error("bad B");
  a_clk_live: assert property (rdS |=> avs_readdata[16] == $past(counterClockOn))
    else $error("bad clock bit");
  a_stat_blank: assert property (rdS |=> avs_readdata[31:19] == 0 && avs_readdata[15:8] == 0)
    else $error("bad spare bits");
  a_wave_gate: assert property (rdS && waveMode && $past(waveMode)
    |=> avs_readdata[6:5] == 0 && !avs_readdata[1]) else $error("capture flag in waveform");
  a_irq_off: assert property (wrT && avs_address == 8'h28 && avs_writedata[7:0] == 8'hff
    |-> ##2 !irqOut) else $error("irq while masked");
  c_stat_read: cover property (rdS);
  c_irq_high: cover property (irqOut);
  c_wave_write: cover property (wrT && waveMode);
endmodule // tcsr_chk
bind tcsr_chan_regs tcsr_chk chk_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .waveMode, .counterClockOn,
  .compareBValue, .periodCompareValue, .irqOut);

// ===== bench/tcsr_cnt_model.sv
// Counter-side model: turns held event requests into one-cycle pulses.
// Assumes requests change just after a rising core_clk edge.
`timescale 1ns/1ps
module tcsr_cnt_model (
  input wire core_clk,
  input wire [6:0] req,
  output reg [6:0] pulse
);
  reg [6:0] lastReq_q = 7'h00;
  // One pulse per rising request
  always @(posedge core_clk) begin
    pulse <= req & ~lastReq_q;
    lastReq_q <= req;
  end
endmodule // tcsr_cnt_model

// ===== bench/tcsr_chan_regs_test.sv
// Self-checking bench for the timer channel register block.
// Assumes the counter model supplies event pulses; every wait is bounded.
`timescale 1ns/1ps
module tcsr_chan_regs_test;
  reg core_clk = 0, rst = 1, rd = 0, wr = 0, mode = 0, clkOn = 0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, q;
  reg [6:0] req = 7'h00;
  reg [3:0] pins = 4'h0;
  wire [6:0] ev;
  wire [31:0] rdat;
  wire avsWait, irq;
  wire [15:0] bVal, cVal;
  integer error_cnt = 0, checks_done = 0;
  tcsr_cnt_model cnt_u (.core_clk(core_clk), .req(req), .pulse(ev));
  tcsr_chan_regs dut_u (.core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(avsWait), .waveMode(mode), .overflowEvt(ev[0]), .matchAEvt(ev[1]),
    .matchBEvt(ev[2]), .matchCEvt(ev[3]), .loadAEvt(ev[4]), .loadBEvt(ev[5]),
    .captureAIn(16'h1111), .captureBIn(16'hbeef), .extTriggerEvt(ev[6]),
    .counterClockOn(clkOn), .chanIoAPin(pins[0]), .chanIoBPin(pins[1]),
    .chanIoADrive(pins[2]), .chanIoBDrive(pins[3]), .compareBValue(bVal),
    .periodCompareValue(cVal), .irqOut(irq));
  // Clock of 40 ns period
  initial forever #20 core_clk = ~core_clk;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Bus access held until waitrequest is sampled low
  task acc(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
        @(posedge core_clk);
        n = n + 1;
      end while (avsWait !== 1'b0 && n < 50);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 50) begin
        error_cnt = error_cnt + 1;
        test_done;
      end
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      acc(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask
  // Raise event requests for one cycle, then let the flags settle
  task fire(input [6:0] m);
    begin
      @(posedge core_clk);
      req <= m;
      @(posedge core_clk);
      req <= 7'h00;
      repeat (3) @(posedge core_clk);
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdc(8'h1c, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h2c, 32'h0);
    acc(1'b1, 8'h1c, 32'hffff1234);
    rdc(8'h1c, 32'h1234);
    chk(cVal, 32'h1234);
    acc(1'b1, 8'h18, 32'h5555);
    fire(7'h7f);
    fire(7'h10);
    rdc(8'h18, 32'hbeef);
    chk(bVal, 32'hbeef);
    clkOn <= 1'b1;
    pins <= 4'h9;
    repeat (3) @(posedge core_clk);
    rdc(8'h20, 32'h000300f3);
    rdc(8'h20, 32'h00030000);
    $display("capture test done");
    mode <= 1'b1;
    acc(1'b1, 8'h18, 32'h0abc);
    rdc(8'h18, 32'h0abc);
    chk(bVal, 32'h0abc);
    fire(7'h7f);
    rdc(8'h20, 32'h0005009d);
    $display("waveform test done");
    acc(1'b1, 8'h24, 32'hffffff11);
    rdc(8'h2c, 32'h11);
    fire(7'h01);
    chk(irq, 1);
    rdc(8'h20, 32'h00050001);
    chk(irq, 0);
    fire(7'h40);
    chk(irq, 0);
    acc(1'b1, 8'h28, 32'h01);
    rdc(8'h2c, 32'h10);
    rdc(8'h20, 32'h00050080);
    fire(7'h01);
    chk(irq, 0);
    fire(7'h08);
    chk(irq, 1);
    acc(1'b1, 8'h28, 32'hff);
    rdc(8'h2c, 32'h0);
    rdc(8'h40, 32'h0);
    $display("interrupt test done");
    test_done;
  end
endmodule // tcsr_chan_regs_test
